// ===== rtl/mdf_fault_cfg.sv
// mdf_fault_cfg: fault mask, trip point, persistence and alert pin logic.
// assumes a byte register port in the clock domain and synchronous raw faults.
`timescale 1ns/100ps
`default_nettype none

module mdf_fault_cfg #(
  parameter int TICK_CYCLES = mdf_pkg::MDF_TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire mdf_pkg::mdf_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [3:0][6:0] fault_raw_i,
  input wire logic boost_raw_i,
  output var mdf_pkg::mdf_trip_t trip_o,
  output var mdf_pkg::mdf_hyst_t hyst_o,
  output logic alert_o,
  output logic alert_oe_n_o
);
  import mdf_pkg::*;

  // ==========================================================================
  // registers
  logic [7:0] pin_ctrl_reg;
  logic [7:0] type_mask_reg;
  logic [7:0] thresh_reg;
  logic [7:0] timeout_reg;
  logic [3:0][6:0] reported;
  logic boost_reported;
  logic [7:0] limit_ms;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic active;
  logic [2:0] rd_index;

  // status bank decode: bit 2 flags a hit, bits 1:0 pick the channel
  function automatic logic [2:0] status_index(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - MDF_OFS_STATUS_BASE;
    status_index = (addr >= MDF_OFS_STATUS_BASE && d < 8'h04) ? {1'b1, d[1:0]} : 3'h0;
  endfunction

  // a call result cannot be bit-selected, so the decode lands on a net first
  assign rd_index = status_index(reg_req_i.addr);

  // ==========================================================================
  // register writes
  // persistence code resets to 2
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_ctrl_reg <= MDF_RST_PIN_CTRL;
      type_mask_reg <= MDF_RST_TYPE_MASK;
      thresh_reg <= MDF_RST_THRESH;
      timeout_reg <= MDF_RST_TIMEOUT;
    end else if (reg_req_i.wr) begin
      if (reg_req_i.addr == MDF_OFS_PIN_CTRL) begin
        pin_ctrl_reg <= reg_req_i.wdata;
      end else if (reg_req_i.addr == MDF_OFS_TYPE_MASK) begin
        type_mask_reg <= reg_req_i.wdata;
      end else if (reg_req_i.addr == MDF_OFS_THRESH) begin
        if (reg_req_i.wdata[MDF_POS_BRIDGE +: 2] == MDF_BRIDGE_RESERVED) begin
          thresh_reg <= {thresh_reg[MDF_POS_BRIDGE +: 2], reg_req_i.wdata[5:0]};
        end else begin
          thresh_reg <= reg_req_i.wdata;
        end
      end else if (reg_req_i.addr == MDF_OFS_TIMEOUT) begin
        timeout_reg <= reg_req_i.wdata;
      end
    end
  end

  // ==========================================================================
  // register reads, answered one cycle after the read strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.rd) begin
      if (rd_index[2]) begin
        reg_rdata_o <= {1'b0, reported[rd_index[1:0]]};
      end else if (reg_req_i.addr == MDF_OFS_PIN_CTRL) begin
        reg_rdata_o <= pin_ctrl_reg;
      end else if (reg_req_i.addr == MDF_OFS_TYPE_MASK) begin
        reg_rdata_o <= type_mask_reg;
      end else if (reg_req_i.addr == MDF_OFS_THRESH) begin
        reg_rdata_o <= thresh_reg;
      end else if (reg_req_i.addr == MDF_OFS_TIMEOUT) begin
        reg_rdata_o <= timeout_reg;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // comparator trip codes and hysteresis, straight from flops
  // bridge window
  assign trip_o.bridge_window_select = thresh_reg[MDF_POS_BRIDGE +: 2];
  assign trip_o.bias_short_level_select = thresh_reg[MDF_POS_BIAS +: 2];
  assign trip_o.ground_short_level_select = thresh_reg[MDF_POS_GROUND +: 2];
  assign trip_o.battery_short_level_select = thresh_reg[MDF_POS_BATTERY +: 2];
  assign hyst_o.bias_short_hysteresis_on = timeout_reg[MDF_BIT_HYST_BIAS];
  assign hyst_o.ground_short_hysteresis_on = timeout_reg[MDF_BIT_HYST_GROUND];
  assign hyst_o.battery_short_hysteresis_on = timeout_reg[MDF_BIT_HYST_BATTERY];

  // ==========================================================================
  // 1 ms enable; ms granularity keeps each filter counter at 8 bits
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  always_comb begin
    case (timeout_reg[MDF_POS_PERSIST +: 2])
      MDF_PERSIST_NONE: limit_ms = 8'h00;
      MDF_PERSIST_50: limit_ms = MDF_PERSIST_50_MS;
      MDF_PERSIST_100: limit_ms = MDF_PERSIST_100_MS;
      default: limit_ms = MDF_PERSIST_150_MS;
    endcase
  end

  // ==========================================================================
  // one filter per channel and fault type
  for (genvar c = 0; c < MDF_CHANNELS; c++) begin : g_chan
    for (genvar t = 0; t < MDF_TYPES; t++) begin : g_type
      mdf_persist u_persist (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick),
        .raw_i(fault_raw_i[c][t]),
        .limit_ms_i(limit_ms),
        .reported_o(reported[c][t])
      );
    end
  end

  mdf_persist u_boost_persist (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .raw_i(boost_raw_i),
    .limit_ms_i(limit_ms),
    .reported_o(boost_reported)
  );

  // ==========================================================================
  // alert gating: type mask bits sit on the same positions as report bits
  // boost mask
  always_comb begin
    active = boost_reported && !type_mask_reg[MDF_BIT_BOOST_MASK];
    for (int c = 0; c < MDF_CHANNELS; c++) begin
      if (!pin_ctrl_reg[c]) begin
        active = active || |(reported[c] & ~(type_mask_reg[6:0] & MDF_TYPE_MASKABLE));
      end
    end
  end

  // ==========================================================================
  // pin stage; release bit holds the pin idle while set
  // active level
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      alert_o <= ~MDF_RST_PIN_CTRL[MDF_BIT_ACTIVE_LEVEL];
      alert_oe_n_o <= MDF_RST_PIN_CTRL[MDF_BIT_DRIVE_OPT];
    end else begin
      alert_o <= (active && !pin_ctrl_reg[MDF_BIT_PIN_RELEASE])
                 ~^ pin_ctrl_reg[MDF_BIT_ACTIVE_LEVEL];
      alert_oe_n_o <= pin_ctrl_reg[MDF_BIT_DRIVE_OPT]
                      && !(active && !pin_ctrl_reg[MDF_BIT_PIN_RELEASE]);
    end
  end

endmodule // mdf_fault_cfg
`default_nettype wire

// ===== rtl/mdf_pkg.sv
// mdf_pkg: shared constants and types for the mic fault diagnostics block.
// assumes one 200 MHz clock and a byte-wide register port.
package mdf_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] MDF_OFS_STATUS_BASE = 8'h11;  // channel 1 report, next three follow
  localparam logic [7:0] MDF_OFS_PIN_CTRL = 8'h15;
  localparam logic [7:0] MDF_OFS_TYPE_MASK = 8'h16;
  localparam logic [7:0] MDF_OFS_THRESH = 8'h17;
  localparam logic [7:0] MDF_OFS_TIMEOUT = 8'h18;

  // ==========================================================================
  // reset values
  localparam logic [7:0] MDF_RST_PIN_CTRL = 8'h20;
  localparam logic [7:0] MDF_RST_TYPE_MASK = 8'h00;
  localparam logic [7:0] MDF_RST_THRESH = 8'h00;
  localparam logic [7:0] MDF_RST_TIMEOUT = 8'h20;

  // ==========================================================================
  // field positions
  localparam int MDF_BIT_BOOST_MASK = 7;
  localparam int MDF_BIT_PIN_RELEASE = 6;
  localparam int MDF_BIT_DRIVE_OPT = 5;
  localparam int MDF_BIT_ACTIVE_LEVEL = 4;
  localparam int MDF_POS_BRIDGE = 6;
  localparam int MDF_POS_BIAS = 4;
  localparam int MDF_POS_GROUND = 2;
  localparam int MDF_POS_BATTERY = 0;
  localparam int MDF_POS_PERSIST = 4;
  localparam int MDF_BIT_HYST_BIAS = 2;
  localparam int MDF_BIT_HYST_GROUND = 1;
  localparam int MDF_BIT_HYST_BATTERY = 0;
  // type bit 2 (high shorted to bias) has no type mask
  localparam logic [6:0] MDF_TYPE_MASKABLE = 7'h7B;
  localparam logic [1:0] MDF_BRIDGE_RESERVED = 2'h3;

  // ==========================================================================
  // timing
  localparam int MDF_CLK_HZ = 200_000_000;
  localparam int MDF_TICK_MS = 1;
  localparam int MDF_TICK_CYCLES = MDF_CLK_HZ / 1000 * MDF_TICK_MS;
  localparam logic [7:0] MDF_PERSIST_50_MS = 8'h32;
  localparam logic [7:0] MDF_PERSIST_100_MS = 8'h64;
  localparam logic [7:0] MDF_PERSIST_150_MS = 8'h96;
  localparam logic [1:0] MDF_PERSIST_NONE = 2'h0;
  localparam logic [1:0] MDF_PERSIST_50 = 2'h1;
  localparam logic [1:0] MDF_PERSIST_100 = 2'h2;

  localparam int MDF_CHANNELS = 4;
  localparam int MDF_TYPES = 7;

  // ==========================================================================
  // types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mdf_reg_req_t;

  typedef struct packed {
    logic [1:0] bridge_window_select;
    logic [1:0] bias_short_level_select;
    logic [1:0] ground_short_level_select;
    logic [1:0] battery_short_level_select;
  } mdf_trip_t;

  typedef struct packed {
    logic bias_short_hysteresis_on;
    logic ground_short_hysteresis_on;
    logic battery_short_hysteresis_on;
  } mdf_hyst_t;

endpackage

// ===== rtl/mdf_persist.sv
// mdf_persist: one persistence filter for one fault condition.
// assumes the raw condition is synchronous and tick is a one-cycle 1 ms pulse.
`timescale 1ns/100ps
`default_nettype none
module mdf_persist (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic raw_i,
  input wire logic [7:0] limit_ms_i,
  output logic reported_o
);
  import mdf_pkg::*;

  // ==========================================================================
  // elapsed time while the condition stands
  logic [7:0] elapsed_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !raw_i) begin
      elapsed_reg <= 8'h00;
    end else if (tick_i && elapsed_reg != 8'hFF) begin
      elapsed_reg <= elapsed_reg + 8'h01;
    end
  end

  // ==========================================================================
  // report once the limit is reached; a zero limit passes straight through
  // hold before report
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reported_o <= 1'b0;
    end else if (limit_ms_i == 8'h00) begin
      reported_o <= raw_i;
    end else begin
      reported_o <= raw_i && (elapsed_reg >= limit_ms_i);
    end
  end

endmodule // mdf_persist
`default_nettype wire

// ===== verif/mdf_fault_cfg_monitor.sv
// mdf_fault_cfg_chk: port-level checks on the fault config block.
// assumes only reg_req_i writes the control bytes; TICK_CYCLES matches the design.
`timescale 1ns/100ps
`default_nettype none
module mdf_fault_cfg_chk #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire mdf_pkg::mdf_reg_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [3:0][6:0] fault_raw_i,
  input wire logic boost_raw_i,
  input wire mdf_pkg::mdf_trip_t trip_o,
  input wire mdf_pkg::mdf_hyst_t hyst_o,
  input wire logic alert_o,
  input wire logic alert_oe_n_o
);
  import mdf_pkg::*;
  logic [7:0] pc_reg, tm_reg, to_reg;
  logic [10:0] cnt_reg;
  logic act, wr;
  int lim;
  assign wr = reg_req_i.wr;
  assign act = (alert_o == pc_reg[4]) && !alert_oe_n_o;
  assign lim = int'(to_reg[5:4]) * 50 * TICK_CYCLES;
  // ==========================================================================
  // shadow of the pin control, type mask and timeout bytes
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pc_reg <= 8'h20;
      tm_reg <= 8'h00;
      to_reg <= 8'h20;
    end else if (wr) begin
      if (reg_req_i.addr == 8'h15) pc_reg <= reg_req_i.wdata;
      if (reg_req_i.addr == 8'h16) tm_reg <= reg_req_i.wdata;
      if (reg_req_i.addr == 8'h18) to_reg <= reg_req_i.wdata;
    end
  end
  // age of a lone ch1 low-to-ground fault; 7FF poisons it so mixed cases stay unjudged
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !fault_raw_i[0][0]) begin
      cnt_reg <= 11'h000;
    end else if (boost_raw_i || fault_raw_i != 28'h1 || (wr && reg_req_i.addr == 8'h18)) begin
      cnt_reg <= 11'h7FF;
    end else if (cnt_reg != 11'h7FF) begin
      cnt_reg <= cnt_reg + 11'h001;
    end
  end
  // ==========================================================================
  // assertions
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  rst_vals_a: assert property (
    $rose(rst_n_i) |-> trip_o == 8'h00 && hyst_o == 3'h0 && alert_oe_n_o)
    else $error("reset outputs wrong");
  trip_wr_a: assert property (
    wr && reg_req_i.addr == 8'h17 && reg_req_i.wdata[7:6] != 2'h3
    |=> trip_o == $past(reg_req_i.wdata))
    else $error("trip codes not taken");
  bridge_keep_a: assert property (
    wr && reg_req_i.addr == 8'h17 && reg_req_i.wdata[7:6] == 2'h3
    |=> $stable(trip_o.bridge_window_select) && trip_o[5:0] == $past(reg_req_i.wdata[5:0]))
    else $error("reserved window code taken");
  hyst_wr_a: assert property (
    wr && reg_req_i.addr == 8'h18 |=> hyst_o == $past(reg_req_i.wdata[2:0]))
    else $error("hysteresis enables wrong");
  rd_back_a: assert property (
    reg_req_i.rd && reg_req_i.addr == 8'h18 |=> reg_rdata_o == $past(to_reg))
    else $error("timeout byte readback wrong");
  fast_report_a: assert property (
    to_reg[5:4] == 2'h0 && cnt_reg == 11'h003 && !tm_reg[0] && !pc_reg[0] && !pc_reg[6]
    && !$past(wr) |-> act)
    else $error("no-wait fault not on pin");
  persist_early_a: assert property (
    to_reg[5:4] != 2'h0 && cnt_reg > 11'h004 && cnt_reg + TICK_CYCLES + 3 < lim && !$past(wr)
    |-> !act)
    else $error("fault reported too early");
  persist_late_a: assert property (
    to_reg[5:4] != 2'h0 && cnt_reg == lim + 5 && !tm_reg[0] && !pc_reg[0] && !pc_reg[6]
    && !$past(wr) |-> act)
    else $error("fault reported too late");
  quiet_idle_a: assert property (
    (!(boost_raw_i && !tm_reg[7]) && fault_raw_i == 28'h0 && !wr) [*3]
    |=> alert_o == !pc_reg[4] && alert_oe_n_o == pc_reg[5])
    else $error("idle pin level wrong");
  cover property (cnt_reg == 11'h003 && act);
  cover property (to_reg[5:4] != 2'h0 && cnt_reg == lim + 5 && act);
  cover property (wr && reg_req_i.addr == 8'h17 && reg_req_i.wdata[7:6] == 2'h3);
endmodule // mdf_fault_cfg_chk
bind mdf_fault_cfg mdf_fault_cfg_chk #(.TICK_CYCLES(TICK_CYCLES)) u_mdf_fault_cfg_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .fault_raw_i(fault_raw_i), .boost_raw_i(boost_raw_i), .trip_o(trip_o), .hyst_o(hyst_o),
  .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o));
`default_nettype wire

// ===== verif/mdf_host_model.sv
// mdf_host_model: host watching the shared alert wire.
// assumes a board pull-up; active-high with release-when-idle reads as a fault.
`timescale 1ns/100ps
`default_nettype none
module mdf_host_model (
  input wire logic alert_i,
  input wire logic alert_oe_n_i,
  input wire logic level_i,
  output logic seen_o
);
  logic wire_lvl;
  // released wire floats to the pull-up level
  assign wire_lvl = alert_oe_n_i ? 1'b1 : alert_i;
  assign seen_o = (wire_lvl === level_i);
endmodule // mdf_host_model
`default_nettype wire

// ===== verif/tb_top.sv
// tb_top: self-checking bench for the fault config block.
// assumes TICK_CYCLES of 10, so 1 ms is 10 clocks.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import mdf_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  mdf_reg_req_t req = '0;
  logic [3:0][6:0] raw = '0;
  logic boost = 1'b0;
  logic level = 1'b0;
  logic pin_chk = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] rdata, exp_v, th, w;
  logic [7:0] exp_q[$];
  mdf_trip_t trip;
  mdf_hyst_t hyst;
  logic alert, oe_n, seen;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int lim;
  int ch;
  always #2.5 clk_sys_i = ~clk_sys_i;
  mdf_fault_cfg #(.TICK_CYCLES(10)) u_mdf_fault_cfg (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .fault_raw_i(raw), .boost_raw_i(boost),
    .trip_o(trip), .hyst_o(hyst), .alert_o(alert), .alert_oe_n_o(oe_n));
  mdf_host_model u_mdf_host_model (.alert_i(alert), .alert_oe_n_i(oe_n), .level_i(level),
    .seen_o(seen));
  // ==========================================================================
  // drivers: one request per falling edge, held until the next
  task automatic bus(input logic w_en, input logic r_en, input logic [7:0] a, input logic [7:0] d);
    req = '{w_en, r_en, a, d};
    @(negedge clk_sys_i);
  endtask
  task automatic idle();
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic pin(input logic e);
    exp_q.push_back({7'h00, e});
    pin_chk = 1'b1;
    @(negedge clk_sys_i);
    pin_chk = 1'b0;
  endtask
  task automatic end_of_test();
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // result watcher: oldest note against read data or wire state
  always @(posedge clk_sys_i) begin
    rd_q <= req.rd;
    if (rd_q || pin_chk) begin
      exp_v = exp_q.pop_front();
      `CHK((rd_q ? rdata : {7'h00, seen}), exp_v)
    end
  end
  // hang guard, well above the ~4900 clocks the sequence needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(83));
    repeat (8) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    rd(8'h16, 8'h00);
    rd(8'h17, 8'h00);
    rd(8'h18, 8'h20);
    rd(8'h15, 8'h20);
    rd(8'h30, 8'h00);
    th = 8'h00;
    // reserved window code must leave the old field in place
    repeat (12) begin
      // first pass always tries the reserved window code
      w = 8'($urandom()) | ((th == 8'h00) ? 8'hC0 : 8'h00);
      bus(1'b1, 1'b0, 8'h17, w);
      if (w[7:6] != 2'h3) th[7:6] = w[7:6];
      th[5:0] = w[5:0];
      rd(8'h17, th);
      bus(1'b1, 1'b0, 8'h18, w);
      rd(8'h18, w);
    end
    bus(1'b1, 1'b0, 8'h18, 8'h00);
    bus(1'b1, 1'b0, 8'h15, 8'h00);
    idle();
    // each type unmasked then masked; type 2 has no mask of its own
    for (int t = 0; t < 16; t++) begin
      bus(1'b1, 1'b0, 8'h16, t[3] ? 8'h01 << t[2:0] : 8'h00);
      idle();
      // first pass pins channel 1 so the no-wait assertion gets its lone fault
      ch = (t == 0) ? 0 : $urandom_range(3, 0);
      if (t[2:0] == 3'h7) boost = 1'b1;
      else raw[ch][t[2:0]] = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      pin(!t[3] || t[2:0] == 3'h2);
      // status shows a channel fault whatever the type mask says; a boost pass reads 00
      rd(8'h11 + 8'(ch), (t[2:0] == 3'h7) ? 8'h00 : 8'h01 << t[2:0]);
      idle();
      raw = '0;
      boost = 1'b0;
      repeat (4) @(negedge clk_sys_i);
    end
    bus(1'b1, 1'b0, 8'h16, 8'h00);
    bus(1'b1, 1'b0, 8'h15, 8'h01);
    idle();
    raw[0][3] = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    pin(1'b0);
    raw[1][3] = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    pin(1'b1);
    bus(1'b1, 1'b0, 8'h15, 8'h10);
    idle();
    level = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    pin(1'b1);
    bus(1'b1, 1'b0, 8'h15, 8'h50);
    idle();
    repeat (3) @(negedge clk_sys_i);
    pin(1'b0);
    raw = '0;
    level = 1'b0;
    bus(1'b1, 1'b0, 8'h15, 8'h00);
    idle();
    // each nonzero timeout code, with a short dropout halfway to restart the timer
    for (int k = 1; k < 4; k++) begin
      lim = k * 500;
      bus(1'b1, 1'b0, 8'h18, 8'(k << 4));
      idle();
      raw[0][0] = 1'b1;
      repeat (lim / 2) @(negedge clk_sys_i);
      raw[0][0] = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      raw[0][0] = 1'b1;
      repeat (lim - 30) @(negedge clk_sys_i);
      pin(1'b0);
      repeat (40) @(negedge clk_sys_i);
      pin(1'b1);
      raw[0][0] = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      pin(1'b0);
    end
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
